// file: hw/lcd_segment_driver_control.sv
// Segment display controller: APB registers, display memory and common/segment scan.
// Assumes instruction and subclock ticks are one-cycle pulses synchronous to ref_clk.
`timescale 1ns/100ps
module lcd_segment_driver_control
    import lcd_pkg::*;
#(
    parameter int ADDR_W = 10
)
(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    // APB slave
    input  wire logic [ADDR_W-1:0]      paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // System timing and mode
    input  wire logic                   instr_tick,
    input  wire logic                   sub_tick,
    input  wire logic                   timer_a_mode_high_bit,
    input  wire logic                   low_power_mode,
    // Panel side
    output logic      [COM_COUNT-1:0]   common_line,
    output logic      [SEG_COUNT-1:0]   segment_line,
    output logic      [GROUP_COUNT-1:0] segment_pin_en,
    output logic                        drive_power_switch,
    output logic                        pins_grounded
);

    // ==========================================================================
    // Registers and storage
    logic [3:0]           display_control_reg;
    logic [3:0]           duty_clock_reg;
    logic [3:0]           segment_pin_select_reg;
    logic [3:0]           disp_ram_reg [SEG_COUNT];
    logic [1:0]           phase_reg;
    logic [1:0]           phase_next;
    logic [SEG_COUNT-1:0] seg_next;
    logic                 display_tick;

    // ==========================================================================
    // APB decode
    wire [IDX_W-1:0] idx       = paddr[ADDR_W-1:2];
    wire             setup     = psel && !penable;
    wire             access    = psel && penable && pready;
    wire             hit_ctrl  = (idx == IDX_DISPLAY_CONTROL);
    wire             hit_duty  = (idx == IDX_DUTY_CLOCK);
    wire             hit_sel   = (idx == IDX_SEG_PIN_SELECT);
    wire             hit_stat  = (idx == IDX_STATUS);
    wire             hit_ram   = (idx >= IDX_RAM_FIRST) && (idx <= IDX_RAM_LAST);
    wire             mapped    = hit_ctrl || hit_duty || hit_sel || hit_stat || hit_ram;
    wire [IDX_W-1:0] ram_off   = idx - IDX_RAM_FIRST;
    wire [4:0]       ram_idx   = ram_off[4:0];
    wire             wr_ok     = access && pwrite && mapped;
    wire [3:0]       status    = {low_power_mode, pins_grounded, phase_reg};
    // Control registers are write-only and read back as zero
    wire [3:0]       rd_nibble = hit_ram  ? disp_ram_reg[ram_idx] :
                                 hit_stat ? status : 4'h0;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            // Zero wait states: answer is prepared in the setup cycle
            pready  <= 1'b1;
            if (setup) begin
                prdata  <= {28'h000_0000, rd_nibble};
                pslverr <= !mapped;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            display_control_reg    <= CTRL_RESET;
            duty_clock_reg         <= DUTY_CLOCK_RESET;
            segment_pin_select_reg <= SEG_SELECT_RESET;
        end else if (wr_ok) begin
            if (hit_ctrl)
                display_control_reg    <= {1'b0, pwdata[2:0]};
            if (hit_duty)
                duty_clock_reg         <= pwdata[3:0];
            if (hit_sel)
                segment_pin_select_reg <= pwdata[3:0];
        end
    end

    // Display memory is written only by software; the scan reads it directly
    always_ff @(posedge ref_clk) begin
        if (wr_ok && hit_ram)
            disp_ram_reg[ram_idx] <= pwdata[3:0];
    end

    // ==========================================================================
    // Display clock
    lcd_clock_divider u_divider (
        .ref_clk               (ref_clk),
        .reset_n               (reset_n),
        .clock_select          (clk_sel_t'(duty_clock_reg[3:2])),
        .timer_a_mode_high_bit (timer_a_mode_high_bit),
        .instr_tick            (instr_tick),
        .sub_tick              (sub_tick),
        .display_tick          (display_tick)
    );

    // ==========================================================================
    // Common phase scan
    wire duty_t duty       = duty_t'(duty_clock_reg[1:0]);
    wire [1:0]  last_phase = (duty == duty_quarter) ? 2'd3 :
                             (duty == duty_third)   ? 2'd2 :
                             (duty == duty_half)    ? 2'd1 : 2'd0;
    wire        grounded   = low_power_mode && !display_control_reg[CTRL_LOWPOWER_BIT];
    wire        show       = display_control_reg[CTRL_DISPLAY_BIT] && !grounded;

    always_comb begin
        // A duty change can leave the phase beyond the new last one
        if (phase_reg > last_phase)
            phase_next = 2'd0;
        else if (display_tick)
            phase_next = (phase_reg == last_phase) ? 2'd0 : phase_reg + 2'd1;
        else
            phase_next = phase_reg;
    end

    // ==========================================================================
    // Segment data per line; lines in unselected port groups stay low
    for (genvar s = 0; s < SEG_COUNT; s++) begin : g_seg
        localparam int GRP = s / GROUP_W;
        wire group_on = (GRP >= GROUP_COUNT) ? 1'b1 : segment_pin_select_reg[GRP % GROUP_COUNT];
        assign seg_next[s] = show && group_on && disp_ram_reg[s][phase_reg];
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg          <= 2'd0;
            common_line        <= 4'h0;
            segment_line       <= 24'h00_0000;
            segment_pin_en     <= 4'h0;
            drive_power_switch <= 1'b0;
            pins_grounded      <= 1'b0;
        end else begin
            phase_reg          <= phase_next;
            common_line        <= grounded ? 4'h0 : (4'h1 << phase_reg);
            segment_line       <= seg_next;
            segment_pin_en     <= segment_pin_select_reg;
            drive_power_switch <= display_control_reg[CTRL_POWER_BIT] && !grounded;
            pins_grounded      <= grounded;
        end
    end

    // ==========================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    blank_seg_off_a: assert property (
        !display_control_reg[CTRL_DISPLAY_BIT] |=> (segment_line == 24'h00_0000))
        else $error("segments driven while blanked");
    lowpower_ground_a: assert property (
        (low_power_mode && !display_control_reg[CTRL_LOWPOWER_BIT]) |=>
        (common_line == 4'h0) && (segment_line == 24'h00_0000) && !drive_power_switch)
        else $error("pins not grounded in low-power mode");
    phase_wrap_a: assert property (
        (display_tick && phase_reg == last_phase) |=> (phase_reg == 2'd0))
        else $error("phase did not wrap at frame end");
    phase_step_a: assert property (
        (display_tick && phase_reg < last_phase) |=> (phase_reg == $past(phase_reg) + 2'd1))
        else $error("phase did not step upward");
    com_select_a: assert property (
        !grounded |=> (common_line == (4'h1 << $past(phase_reg))))
        else $error("wrong common active");
    static_phase_a: assert property (
        (duty == duty_static)[*2] |-> (phase_reg == 2'd0))
        else $error("static drive left first common");
    seg_data_a: assert property (
        (show && segment_pin_select_reg[0]) |=>
        (segment_line[0] == $past(disp_ram_reg[0][phase_reg])))
        else $error("segment does not show memory bit");
    power_switch_a: assert property (
        !grounded |=> (drive_power_switch == $past(display_control_reg[CTRL_POWER_BIT])))
        else $error("power switch does not follow control");
    group_enable_a: assert property (
        !segment_pin_select_reg[1] |=> (segment_line[7:4] == 4'h0))
        else $error("unselected group drives segments");

    static_frame_c:  cover property ((duty == duty_static) && display_tick);
    quarter_frame_c: cover property (display_tick && phase_reg == 2'd3);
    grounded_c:      cover property (pins_grounded);
    blank_c:         cover property (!display_control_reg[CTRL_DISPLAY_BIT] && display_tick);

endmodule

// file: pkg/lcd_pkg.sv
// Constants and types shared by the segment display controller and its clock divider.
// Assumes register indices are word indices: byte address is four times the index.
package lcd_pkg;

    // ==========================================================================
    // Register map (word indices)
    localparam int            IDX_W                = 8;
    localparam logic [7:0]    IDX_DISPLAY_CONTROL  = 8'h13;
    localparam logic [7:0]    IDX_DUTY_CLOCK       = 8'h14;
    localparam logic [7:0]    IDX_SEG_PIN_SELECT   = 8'h15;
    localparam logic [7:0]    IDX_RAM_FIRST        = 8'h50;
    localparam logic [7:0]    IDX_RAM_LAST         = 8'h67;
    localparam logic [7:0]    IDX_STATUS           = 8'h70;

    // ==========================================================================
    // Field positions and reset values
    localparam int            CTRL_DISPLAY_BIT     = 0;
    localparam int            CTRL_POWER_BIT       = 1;
    localparam int            CTRL_LOWPOWER_BIT    = 2;
    localparam logic [3:0]    CTRL_RESET           = 4'h0;
    localparam logic [3:0]    DUTY_CLOCK_RESET     = 4'h0;
    localparam logic [3:0]    SEG_SELECT_RESET     = 4'h0;

    // ==========================================================================
    // Geometry
    localparam int            SEG_COUNT            = 24;
    localparam int            COM_COUNT            = 4;
    localparam int            GROUP_COUNT          = 4;
    localparam int            GROUP_W              = 4;

    // ==========================================================================
    // Display clock division ratios, counted in source ticks
    localparam logic [12:0]   DIV_SUBCLOCK_64      = 13'h0040;
    localparam logic [12:0]   DIV_INSTR_256        = 13'h0100;
    localparam logic [12:0]   DIV_INSTR_2048       = 13'h0800;
    localparam logic [12:0]   DIV_INSTR_4096       = 13'h1000;
    localparam logic [12:0]   DIV_SUBCLOCK_512     = 13'h0200;

    typedef enum logic [1:0] {
        subclock_div64        = 2'b00,
        instr_clock_div256    = 2'b01,
        instr_clock_div2048   = 2'b10,
        timer_dependent_clock = 2'b11
    } clk_sel_t;

    typedef enum logic [1:0] {
        duty_quarter = 2'b00,
        duty_third   = 2'b01,
        duty_half    = 2'b10,
        duty_static  = 2'b11
    } duty_t;

endpackage

// file: hw/lcd_clock_divider.sv
// Display clock divider: turns instruction or subclock ticks into a display tick.
// Assumes both source ticks are one-cycle pulses synchronous to ref_clk.
`timescale 1ns/100ps
module lcd_clock_divider
    import lcd_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Selection
    input  wire clk_sel_t    clock_select,
    input  wire logic        timer_a_mode_high_bit,
    // Source ticks
    input  wire logic        instr_tick,
    input  wire logic        sub_tick,
    // Result
    output logic             display_tick
);

    // ==========================================================================
    // Source and ratio decode
    logic [12:0] limit;
    logic [12:0] count_reg;
    clk_sel_t    sel_prev_reg;
    logic        tma_prev_reg;

    wire   use_sub  = (clock_select == subclock_div64) ||
                      ((clock_select == timer_dependent_clock) && timer_a_mode_high_bit);
    wire   src_tick = use_sub ? sub_tick : instr_tick;
    // Restart on any change so the first period after a switch is a full one
    wire   changed  = (sel_prev_reg != clock_select) || (tma_prev_reg != timer_a_mode_high_bit);
    wire   at_end   = (count_reg == limit - 13'h0001);

    always_comb begin
        unique case (clock_select)
            subclock_div64:      limit = DIV_SUBCLOCK_64;
            instr_clock_div256:  limit = DIV_INSTR_256;
            instr_clock_div2048: limit = DIV_INSTR_2048;
            timer_dependent_clock: begin
                limit = timer_a_mode_high_bit ? DIV_SUBCLOCK_512 : DIV_INSTR_4096;
            end
        endcase
    end

    // ==========================================================================
    // Counter
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg    <= 13'h0000;
            sel_prev_reg <= subclock_div64;
            tma_prev_reg <= 1'b0;
            display_tick <= 1'b0;
        end else begin
            sel_prev_reg <= clock_select;
            tma_prev_reg <= timer_a_mode_high_bit;
            display_tick <= src_tick && at_end && !changed;
            if (changed)
                count_reg <= 13'h0000;
            else if (src_tick)
                count_reg <= at_end ? 13'h0000 : count_reg + 13'h0001;
        end
    end

    // ==========================================================================
    // Checks
    divider_period_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        display_tick |-> $past(src_tick) && ($past(count_reg) == $past(limit) - 13'h0001))
        else $error("display tick without full division period");
    timer_clock_ratio_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clock_select == timer_dependent_clock) |->
        (limit == (timer_a_mode_high_bit ? 13'h0200 : 13'h1000)))
        else $error("timer dependent ratio wrong");

endmodule

// file: testbench/panel_model.sv
// Passive glass panel model: watches the common electrodes of the controller.
// Assumes one clock; reports phase step spacing and out-of-order common steps.
`timescale 1ns/100ps
module panel_model (
    // Clock
    input  wire logic       ref_clk,
    // Electrodes
    input  wire logic [3:0] common_line,
    // Observations
    output int              step_cycles,
    output int              order_errors
);
    int         count    = 0;
    int         steps    = 0;
    int         errs     = 0;
    logic [3:0] last_com = 4'h0;

    // ==========================================================================
    // Step tracking; an all-low common means grounded, so it starts a new run
    always @(posedge ref_clk) begin
        count <= count + 1;
        if (common_line !== last_com) begin
            if (last_com != 4'h0 && common_line != 4'h0 && common_line != 4'h1
                && common_line !== (last_com << 1))
                errs <= errs + 1;
            if (last_com != 4'h0 && common_line != 4'h0)
                steps <= count;
            count    <= 1;
            last_com <= common_line;
        end
    end
    assign step_cycles  = steps;
    assign order_errors = errs;
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the segment display controller, driven over APB.
// Assumes both source ticks pulse every second cycle, so N ticks take 2N cycles.
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
    import lcd_pkg::*;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [9:0]  paddr   = 10'h000;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        instr_tick = 1'b0;
    logic        sub_tick   = 1'b0;
    logic        tma_bit    = 1'b0;
    logic        low_power  = 1'b0;
    logic [3:0]  common_line;
    logic [23:0] segment_line;
    logic [3:0]  segment_pin_en;
    logic        drive_power_switch;
    logic        pins_grounded;
    int          step_cycles;
    int          order_errors;
    int          failures   = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    int          n;
    logic [31:0] rd;
    logic        err;
    logic [3:0]  mem [24];
    int          div_exp [4] = '{256, 2048, 4096, 512};

    lcd_segment_driver_control #(.ADDR_W(10)) uut (
        .ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr_tick(instr_tick),
        .sub_tick(sub_tick), .timer_a_mode_high_bit(tma_bit),
        .low_power_mode(low_power), .common_line(common_line),
        .segment_line(segment_line), .segment_pin_en(segment_pin_en),
        .drive_power_switch(drive_power_switch), .pins_grounded(pins_grounded));
    panel_model panel (.ref_clk(ref_clk), .common_line(common_line),
        .step_cycles(step_cycles), .order_errors(order_errors));

    // ==========================================================================
    // Clock, source ticks and hang guard
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        instr_tick <= ~instr_tick;
        sub_tick   <= ~sub_tick;
        cycles     <= cycles + 1;
        if (cycles == 90000) begin
            failures++;
            final_report();
        end
    end

    // ==========================================================================
    // Tasks
    task automatic final_report();
        $display("compared %0d, mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Request is held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Returns once the panel model has logged the new step
    task automatic wait_com();
        logic [3:0] old;
        old = common_line;
        @(negedge ref_clk);
        while (common_line === old) @(negedge ref_clk);
        @(negedge ref_clk);
    endtask
    function automatic logic [23:0] seg_exp(input logic [3:0] com, input logic [3:0] grp);
        logic [23:0] r;
        int p;
        p = com[1] ? 1 : com[2] ? 2 : com[3] ? 3 : 0;
        for (int s = 0; s < 24; s++) r[s] = mem[s][p] & (s >= 16 || grp[s / 4]);
        return r;
    endfunction

    // ==========================================================================
    // Tests
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(negedge ref_clk);
        `CHK(segment_line, 24'h0)
        for (int s = 0; s < 24; s++) begin
            mem[s] = 4'(s * 7 + 3);
            apb(1'b1, IDX_RAM_FIRST + 8'(s), {28'h0, mem[s]});
        end
        apb(1'b0, IDX_RAM_LAST, 32'h0);
        `CHK(rd, {28'h0, mem[23]})
        apb(1'b1, 8'hFF, 32'hF);
        `CHK(err, 1'b1)
        apb(1'b0, IDX_DISPLAY_CONTROL, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, IDX_SEG_PIN_SELECT, 32'hF);
        apb(1'b1, IDX_DISPLAY_CONTROL, 32'h3);
        // Register lands at the access edge, the switch output one edge later
        repeat (2) @(negedge ref_clk);
        `CHK(drive_power_switch, 1'b1)
        $display("test registers done");
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, IDX_DUTY_CLOCK, 32'(d));
            if (d == 3) begin
                repeat (300) @(negedge ref_clk);
                `CHK(common_line, 4'h1)
            end else begin
                while (common_line !== 4'h1) wait_com();
                n = 0;
                do begin wait_com(); n++; end while (common_line !== 4'h1);
                `CHK(n, 4 - d)
                `CHK(step_cycles, 128)
            end
            `CHK(segment_line, seg_exp(common_line, 4'hF))
        end
        $display("test duty done");
        for (int c = 1; c < 5; c++) begin
            tma_bit <= (c == 4);
            apb(1'b1, IDX_DUTY_CLOCK, 32'((c > 3 ? 3 : c) << 2));
            wait_com();
            wait_com();
            `CHK(step_cycles, 2 * div_exp[c - 1])
        end
        $display("test clocks done");
        apb(1'b1, IDX_DUTY_CLOCK, 32'h0);
        apb(1'b1, IDX_SEG_PIN_SELECT, 32'h5);
        wait_com();
        `CHK(segment_pin_en, 4'h5)
        `CHK(segment_line, seg_exp(common_line, 4'h5))
        apb(1'b1, IDX_DISPLAY_CONTROL, 32'h2);
        repeat (4) @(negedge ref_clk);
        `CHK(segment_line, 24'h0)
        $display("test segments done");
        apb(1'b1, IDX_DISPLAY_CONTROL, 32'h3);
        low_power <= 1'b1;
        repeat (4) @(negedge ref_clk);
        `CHK(pins_grounded, 1'b1)
        `CHK({common_line, segment_line}, 28'h0)
        `CHK(drive_power_switch, 1'b0)
        apb(1'b0, IDX_STATUS, 32'h0);
        `CHK(rd[3:2], 2'h3)
        apb(1'b1, IDX_DISPLAY_CONTROL, 32'h7);
        // First step leaves ground, second is a partial period, third is full
        wait_com();
        wait_com();
        wait_com();
        `CHK(pins_grounded, 1'b0)
        `CHK(step_cycles, 128)
        low_power <= 1'b0;
        apb(1'b1, IDX_DISPLAY_CONTROL, 32'h1);
        repeat (4) @(negedge ref_clk);
        `CHK(drive_power_switch, 1'b0)
        `CHK(order_errors, 0)
        $display("test low power done");
        final_report();
    end
endmodule
